/* rtl/lrp_regs.vh */
// Register map, field positions and timing for the reset and mode sequencer
// Overview of operation
// - After power-up wait the power-on delay, then launch a system reset.
// - Software reset command or low reset pin also starts a system reset.
// - Reset sets reset-in-progress and busy flags until reset process ends.
// - While reset-in-progress, all register reads work; command and config writes dropped.
// - System reset loads every control register with its default value.
// - Two-bit mode code: reset 00, sleep 10, normal 11; host always active.
// - Only power-on, system reset and display enable change the mode.
// - Display enable command sets mode: bit 0 low sleep, high normal.
// - Sleep stops clock, drivers and pump; draining stays off.
// - Reset drains, stops clock/drivers/pump; normal runs them, no draining.
// - Unused internal drive generator: no pump enable, no drive draining.
// - Drivers stay idle until drive and bias voltage-ready indications.
// - After initial wait, commands are taken back to back with no gaps.
// - Display on/off codes differ only in bit 0, sent as command writes.
// - Display RAM content is untouched by sleep and by reset.
// - Every reset source reinitialises bus state and colour mapping, except a power-on delay that ends with the pin already held low.
`ifndef LRP_REGS_VH
`define LRP_REGS_VH
`define LRP_A_CMD 8'h00
`define LRP_A_STATUS 8'h04
`define LRP_A_CFG 8'h08
`define LRP_CMD_DSEL 8
`define LRP_CMD_SYSRST 8'hE2
`define LRP_CMD_DISP 7'h57
`define LRP_CFG_INTV 0
`define LRP_CFG_DEF 1'b1
`define LRP_ST_BUSY 0
`define LRP_ST_RIP 1
`define LRP_ST_MODE 2
`define LRP_ST_DRV 4
`define LRP_ST_VL 5
`define LRP_ST_VB 6
`define LRP_MODE_RESET 2'b00
`define LRP_MODE_SLEEP 2'b10
`define LRP_MODE_NORMAL 2'b11
`define LRP_CLK_MHZ 125
`define LRP_CLK_NS 8
`define LRP_POR_US 5000
`define LRP_RPROC_NS 200
`define LRP_POR_CYC 20'h9_8968
`define LRP_RPROC_CYC 20'h0_0019
`endif

/* rtl/lrp_sync.v */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module lrp_sync #(
    parameter W = 3,
    parameter [W-1:0] INIT = 3'b111
) (
    input wire mclk,
    input wire reset,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    reg [W-1:0] s1_ff;
    reg [W-1:0] s2_ff;
    reg [W-1:0] s3_ff;
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1)
        begin : g_bit
            always @(posedge mclk or posedge reset)
            begin
                if (reset)
                begin
                    s1_ff[i] <= INIT[i];
                    s2_ff[i] <= INIT[i];
                    s3_ff[i] <= INIT[i];
                    dout[i] <= INIT[i];
                end
                else
                begin
                    s1_ff[i] <= din[i];
                    s2_ff[i] <= s1_ff[i];
                    s3_ff[i] <= s2_ff[i];
                    // Take change once two stages agree
                    if (s2_ff[i] == s3_ff[i])
                        dout[i] <= s3_ff[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* rtl/lrp_timer.v */
// Reloadable down-counter with one-cycle expiry pulse
`timescale 1ns/10ps
`default_nettype none
module lrp_timer #(
    parameter [19:0] RST_VAL = 20'h0_0001
) (
    input wire mclk,
    input wire reset,
    input wire load,
    input wire [19:0] load_val,
    output reg done
);
    reg [19:0] cnt_ff;
    always @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            cnt_ff <= RST_VAL;
            done <= 1'b0;
        end
        else if (load)
        begin
            cnt_ff <= load_val;
            done <= 1'b0;
        end
        else
        begin
            done <= (cnt_ff == 20'h0_0001);
            if (cnt_ff != 20'h0_0000)
                cnt_ff <= cnt_ff - 20'h0_0001;
        end
    end
endmodule
`default_nettype wire

/* rtl/lrp_top.v */
// Reset sequencing and operating-mode control with APB registers
`timescale 1ns/10ps
`default_nettype none
`include "lrp_regs.vh"
module lrp_top #(
    parameter [19:0] POR_CYC = `LRP_POR_CYC
) (
    input wire mclk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire reset_pin_n,
    input wire lcd_drive_voltage_ready,
    input wire vbias_ready,
    output reg [1:0] operating_mode_code,
    output reg reset_in_progress_flag,
    output reg busy_flag,
    output reg clk_run,
    output reg drv_en,
    output reg pump_en,
    output reg drain_lcd_drive_en,
    output reg drain_bias_en,
    output reg bus_init,
    output reg cmap_init,
    output reg ram_we,
    output reg [7:0] ram_wdata
);
    localparam [1:0] S_POR = 2'b00;
    localparam [1:0] S_RST = 2'b01;
    localparam [1:0] S_RUN = 2'b10;
    localparam [19:0] RPROC_CYC = `LRP_RPROC_CYC;

    wire [2:0] pins_s;
    wire pin_low;
    wire vl_ok;
    wire vb_ok;
    wire tmr_done;
    wire acc;
    wire wr_go;
    wire rip_now;
    wire cmd_wr;
    wire cfg_wr;
    wire is_cmd;
    wire sw_rst;
    wire disp_cmd;
    wire data_wr;
    wire mode_norm;
    wire mode_rst;
    wire init_keep;
    reg tmr_load;
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg pin_low_ff;
    reg [1:0] mode_ff;
    reg [1:0] nxt_mode;
    reg cfg_intv_ff;
    reg [8:0] last_cmd_ff;
    reg sys_rst;
    reg [31:0] rd_val;
    reg addr_ok;

    // APB commit strobe
    assign acc = psel & penable & pready;
    assign wr_go = acc & pwrite;
    assign rip_now = (state_ff != S_RUN);
    assign cmd_wr = wr_go & (paddr == `LRP_A_CMD) & ~rip_now;
    assign cfg_wr = wr_go & (paddr == `LRP_A_CFG) & ~rip_now;
    assign is_cmd = cmd_wr & ~pwdata[`LRP_CMD_DSEL];
    assign sw_rst = is_cmd & (pwdata[7:0] == `LRP_CMD_SYSRST);
    assign disp_cmd = is_cmd & (pwdata[7:1] == `LRP_CMD_DISP);
    assign data_wr = cmd_wr & pwdata[`LRP_CMD_DSEL];
    // Mode decodes
    assign mode_norm = (mode_ff == `LRP_MODE_NORMAL);
    assign mode_rst = (mode_ff == `LRP_MODE_RESET);
    assign init_keep = pin_low & pin_low_ff & rip_now;

    lrp_sync #(
        .W(3),
        .INIT(3'b001)
    ) u_sync (
        .mclk(mclk),
        .reset(reset),
        .din({vbias_ready, lcd_drive_voltage_ready, reset_pin_n}),
        .dout(pins_s)
    );
    assign pin_low = ~pins_s[0];
    assign vl_ok = pins_s[1];
    assign vb_ok = pins_s[2];

    lrp_timer #(
        .RST_VAL(POR_CYC)
    ) u_tmr (
        .mclk(mclk),
        .reset(reset),
        .load(tmr_load),
        .load_val(RPROC_CYC),
        .done(tmr_done)
    );

    always @*
    begin
        nxt_state = state_ff;
        sys_rst = 1'b0;
        case (state_ff)
            S_POR:
            begin
                if (tmr_done)
                begin
                    nxt_state = S_RST;
                    sys_rst = 1'b1;
                end
            end
            S_RST:
            begin
                if (pin_low)
                    sys_rst = 1'b1;
                else if (tmr_done)
                    nxt_state = S_RUN;
            end
            S_RUN:
            begin
                if (pin_low | sw_rst)
                begin
                    nxt_state = S_RST;
                    sys_rst = 1'b1;
                end
            end
            default:
            begin
                nxt_state = S_POR;
            end
        endcase
        tmr_load = sys_rst;
    end

    always @*
    begin
        nxt_mode = mode_ff;
        if (sys_rst | (state_ff == S_POR))
            nxt_mode = `LRP_MODE_RESET;
        else if (disp_cmd)
            nxt_mode = pwdata[0] ? `LRP_MODE_NORMAL : `LRP_MODE_SLEEP;
    end

    always @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            state_ff <= S_POR;
            mode_ff <= `LRP_MODE_RESET;
            pin_low_ff <= 1'b0;
            cfg_intv_ff <= `LRP_CFG_DEF;
            last_cmd_ff <= 9'h000;
        end
        else
        begin
            state_ff <= nxt_state;
            mode_ff <= nxt_mode;
            pin_low_ff <= pin_low;
            if (sys_rst)
            begin
                cfg_intv_ff <= `LRP_CFG_DEF;
                last_cmd_ff <= 9'h000;
            end
            else
            begin
                if (cfg_wr)
                    cfg_intv_ff <= pwdata[`LRP_CFG_INTV];
                if (cmd_wr)
                    last_cmd_ff <= pwdata[8:0];
            end
        end
    end

    // Status flags and mode code
    always @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            operating_mode_code <= `LRP_MODE_RESET;
            reset_in_progress_flag <= 1'b1;
            busy_flag <= 1'b1;
        end
        else
        begin
            operating_mode_code <= mode_ff;
            reset_in_progress_flag <= (nxt_state != S_RUN);
            busy_flag <= (nxt_state != S_RUN);
        end
    end

    // Power gates follow the mode
    always @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            clk_run <= 1'b0;
            drv_en <= 1'b0;
            pump_en <= 1'b0;
            drain_lcd_drive_en <= 1'b0;
            drain_bias_en <= 1'b0;
        end
        else
        begin
            clk_run <= mode_norm;
            pump_en <= mode_norm & cfg_intv_ff;
            drv_en <= mode_norm & vl_ok & vb_ok;
            drain_bias_en <= mode_rst;
            drain_lcd_drive_en <= mode_rst & cfg_intv_ff;
        end
    end

    // Host-side strobes
    always @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            bus_init <= 1'b0;
            cmap_init <= 1'b0;
            ram_we <= 1'b0;
            ram_wdata <= 8'h00;
        end
        else
        begin
            bus_init <= sys_rst & ~init_keep;
            cmap_init <= sys_rst & ~init_keep;
            ram_we <= data_wr;
            if (data_wr)
                ram_wdata <= pwdata[7:0];
        end
    end

    always @*
    begin
        addr_ok = 1'b1;
        rd_val = 32'h0000_0000;
        case (paddr)
            `LRP_A_CMD:
                rd_val[8:0] = last_cmd_ff;
            `LRP_A_STATUS:
            begin
                rd_val[`LRP_ST_BUSY] = rip_now;
                rd_val[`LRP_ST_RIP] = rip_now;
                rd_val[`LRP_ST_MODE+1:`LRP_ST_MODE] = mode_ff;
                rd_val[`LRP_ST_DRV] = drv_en;
                rd_val[`LRP_ST_VL] = vl_ok;
                rd_val[`LRP_ST_VB] = vb_ok;
            end
            `LRP_A_CFG:
                rd_val[`LRP_CFG_INTV] = cfg_intv_ff;
            default:
                addr_ok = 1'b0;
        endcase
    end

    always @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (psel & penable & ~pready)
        begin
            pready <= 1'b1;
            pslverr <= ~addr_ok;
            prdata <= pwrite ? 32'h0000_0000 : rd_val;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* verification/lrp_props.sv */
// Port checker for the reset and mode sequencer
`timescale 1ns/10ps
`default_nettype none
module lrp_props (
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] operating_mode_code,
    input wire logic reset_in_progress_flag,
    input wire logic busy_flag,
    input wire logic clk_run,
    input wire logic drv_en,
    input wire logic pump_en,
    input wire logic drain_lcd_drive_en,
    input wire logic drain_bias_en,
    input wire logic bus_init
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    sequence acc_start;
        psel && $rose(penable);
    endsequence
    sequence one_wait;
        !pready ##1 pready;
    endsequence
    apb_wait_a: assert property (acc_start |-> one_wait)
        else $error("access answer not after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    flags_pair_a: assert property (reset_in_progress_flag == busy_flag)
        else $error("reset and busy flags differ");
    mode_code_a: assert property (operating_mode_code != 2'h1)
        else $error("illegal mode code");
    clk_mode_a: assert property (clk_run == (operating_mode_code == 2'h3))
        else $error("clock run does not follow normal mode");
    drain_mode_a: assert property (!$past(reset) |->
        drain_bias_en == (operating_mode_code == 2'h0))
        else $error("draining does not follow reset mode");
    drain_gen_a: assert property (drain_lcd_drive_en |-> drain_bias_en)
        else $error("drive draining outside reset mode");
    pump_gate_a: assert property (pump_en |-> clk_run)
        else $error("pump on outside normal mode");
    drv_gate_a: assert property (drv_en |-> clk_run)
        else $error("drivers on outside normal mode");
    rip_mode_a: assert property (reset_in_progress_flag |=>
        operating_mode_code == 2'h0)
        else $error("mode not reset during reset process");
    init_pulse_a: assert property (bus_init |-> reset_in_progress_flag)
        else $error("bus init outside reset entry");
endmodule
bind lrp_top lrp_props u_props (.mclk, .reset, .psel, .penable, .pready,
    .pslverr, .operating_mode_code, .reset_in_progress_flag, .busy_flag,
    .clk_run, .drv_en, .pump_en, .drain_lcd_drive_en, .drain_bias_en,
    .bus_init);
`default_nettype wire

/* verification/lrp_supply_model.sv */
// Voltage generator model giving ready levels after a ramp
`timescale 1ns/10ps
`default_nettype none
module lrp_supply_model #(
    parameter int RAMP = 20
) (
    input wire logic mclk,
    input wire logic run,
    output logic drive_ok,
    output logic bias_ok
);
    int cnt = 0;
    always @(posedge mclk)
    begin
        cnt <= run ? cnt + 1 : 0;
        drive_ok <= run && cnt >= RAMP;
        bias_ok <= run && cnt >= RAMP + 2;
    end
endmodule
`default_nettype wire

/* verification/lrp_top_tb.sv */
// Self-checking bench for the reset and mode sequencer
`timescale 1ns/10ps
`default_nettype none
module lrp_top_tb;
    logic mclk, reset, psel, penable, pwrite, reset_pin_n, pready, pslverr;
    logic lcd_drive_voltage_ready, vbias_ready, reset_in_progress_flag;
    logic clk_run, drv_en, pump_en, drain_lcd_drive_en, drain_bias_en;
    logic bus_init, cmap_init, ram_we, busy_flag;
    logic [1:0] operating_mode_code;
    logic [7:0] paddr, ram_wdata;
    logic [31:0] pwdata, prdata, rd;
    int fail_count, checks_done, cyc;
    lrp_top #(.POR_CYC(20'h0_0032)) dut (.mclk, .reset, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .reset_pin_n,
        .lcd_drive_voltage_ready, .vbias_ready, .operating_mode_code,
        .reset_in_progress_flag, .busy_flag, .clk_run, .drv_en, .pump_en,
        .drain_lcd_drive_en, .drain_bias_en, .bus_init, .cmap_init,
        .ram_we, .ram_wdata);
    lrp_supply_model supply (.mclk, .run(clk_run),
        .drive_ok(lcd_drive_voltage_ready), .bias_ok(vbias_ready));
    initial
    begin
        mclk = 0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk)
        cyc <= reset ? 0 : cyc + 1;
    task print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        chk(pslverr, a > 8'h08);
        psel <= 0;
        penable <= 0;
        if (n == 50)
        begin
            fail_count++;
            print_verdict;
        end
    endtask
    task automatic wait_for(input logic drv, input logic v);
        int n;
        n = 0;
        while ((drv ? drv_en : reset_in_progress_flag) !== v && n < 200)
        begin
            @(posedge mclk);
            n++;
        end
        if (n == 200)
        begin
            fail_count++;
            print_verdict;
        end
    endtask
    task t_por;
        chk(reset_in_progress_flag, 1);
        apb(1, 8'h08, 32'h0000_0000);
        apb(0, 8'h04, 32'h0000_0000);
        chk(rd[1:0], 2'h3);
        wait_for(0, 0);
        chk(cyc >= 75 && cyc <= 90, 1);
        apb(0, 8'h08, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        chk(operating_mode_code, 2'h0);
        chk(drain_lcd_drive_en, 1);
        apb(0, 8'h0C, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
    endtask
    task t_disp;
        apb(1, 8'h00, 32'h0000_00AF);
        repeat (4) @(posedge mclk);
        chk({operating_mode_code, clk_run, pump_en}, 4'hF);
        chk({drain_bias_en, drv_en}, 2'h0);
        wait_for(1, 1);
        chk(vbias_ready, 1);
        apb(1, 8'h00, 32'h0000_015A);
        @(posedge mclk);
        chk({ram_we, ram_wdata}, 9'h15A);
        apb(1, 8'h00, 32'h0000_00AE);
        repeat (4) @(posedge mclk);
        chk(operating_mode_code, 2'h2);
        chk({clk_run, drv_en, pump_en, drain_bias_en}, 4'h0);
        chk(ram_wdata, 8'h5A);
        apb(0, 8'h04, 32'h0000_0000);
        chk(rd[3:2], 2'h2);
    endtask
    task t_rst;
        apb(1, 8'h08, 32'h0000_0000);
        apb(1, 8'h00, 32'h0000_00E2);
        @(posedge mclk);
        chk({reset_in_progress_flag, bus_init, cmap_init}, 3'h7);
        wait_for(0, 0);
        apb(0, 8'h08, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        apb(0, 8'h00, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk(ram_wdata, 8'h5A);
        apb(1, 8'h08, 32'h0000_0000);
        repeat (3) @(posedge mclk);
        chk({drain_lcd_drive_en, drain_bias_en}, 2'h1);
        apb(1, 8'h00, 32'h0000_00AF);
        repeat (4) @(posedge mclk);
        chk({clk_run, pump_en}, 2'h2);
    endtask
    task t_pin;
        reset_pin_n <= 0;
        repeat (8) @(posedge mclk);
        chk({reset_in_progress_flag, operating_mode_code}, 3'h4);
        reset_pin_n <= 1;
        wait_for(0, 0);
        repeat (2) @(posedge mclk);
        chk(drain_lcd_drive_en, 1);
    endtask
    initial
    begin
        reset = 1;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        reset_pin_n = 1;
        repeat (10) @(posedge mclk);
        reset <= 0;
        t_por;
        t_disp;
        t_rst;
        t_pin;
        print_verdict;
    end
endmodule
`default_nettype wire
